// *** common/vdg_params.svh ***
// register offsets, reset values, field positions and timing counts of the gate and filter bank
`ifndef VDG_PARAMS_SVH
`define VDG_PARAMS_SVH

// register byte offsets
`define VDG_OFS_GAIN_GATE_DELAY   8'h60
`define VDG_OFS_BURST_GATE_DELAY  8'h64
`define VDG_OFS_CONVERTER_IF      8'h68
`define VDG_OFS_EVEN_TIMING       8'h6C
`define VDG_OFS_ODD_TIMING        8'hEC

// reset values
`define VDG_RST_GAIN_GATE_DELAY   8'h68
`define VDG_RST_BURST_GATE_DELAY  8'h5D
`define VDG_RST_CONVERTER_IF      8'h82
`define VDG_RST_TIMING            8'h00
`define VDG_RST_REFERENCE         8'h80

// converter interface fields
`define VDG_CIF_TOP_HI            7
`define VDG_CIF_TOP_LO            6
`define VDG_CIF_RESERVED          5
`define VDG_CIF_GAIN_DISABLE      4
`define VDG_CIF_CLOCK_SLEEP       3
`define VDG_CIF_LUMA_SLEEP        2
`define VDG_CIF_CHROMA_SLEEP      1
`define VDG_CIF_ADAPTIVE          0
`define VDG_CIF_READ_MASK         8'hDF

// timing control fields
`define VDG_VTC_PULSE_WIDTH       7
`define VDG_VTC_TAPS_HI           2
`define VDG_VTC_TAPS_LO           0
`define VDG_VTC_READ_MASK         8'h87

// timing
`define VDG_CLK_MHZ               250
`define VDG_RECOVERY_S            1
`define VDG_RECOVERY_CYCLES       (`VDG_RECOVERY_S * `VDG_CLK_MHZ * 1000000)
`define VDG_HORIZONTAL_RESET_PULSE_WIDE           64
`define VDG_HORIZONTAL_RESET_PULSE_NARROW         32

`endif

// *** common/vdg_pkg.sv ***
// types shared by the gate and filter bank
package vdg_pkg;

  typedef logic [7:0] vdg_byte_t;

  // vertical filter tap codes
  typedef enum logic [2:0] {
    VDG_TAP_INTERP      = 3'h0,
    VDG_TAP_P2_INTERP   = 3'h1,
    VDG_TAP_P3_INTERP   = 3'h2,
    VDG_TAP_P4_INTERP   = 3'h3,
    VDG_TAP_2           = 3'h4,
    VDG_TAP_3           = 3'h5,
    VDG_TAP_4           = 3'h6,
    VDG_TAP_5           = 3'h7
  } vdg_taps_t;

  // horizontal reset pulse sequencer
  typedef enum logic {
    VDG_HR_IDLE,
    VDG_HR_PULSE
  } vdg_hr_state_t;

endpackage : vdg_pkg

// *** design/vdg_vfilter.sv ***
// binomial vertical prefilter with interpolation flag for one column of line samples
`timescale 1ns/10ps
`default_nettype none

module vdg_vfilter
  import vdg_pkg::*;
#(
  parameter int DW = 8
) (
  input  wire logic            sys_clk,
  input  wire logic            srst,
  input  wire logic [2:0]      tap_code,
  input  wire logic [4:0][DW-1:0] col_samples,
  input  wire logic            col_valid,
  output logic      [DW-1:0]   filt_data,
  output logic                 filt_valid,
  output logic                 filt_interpolate
);

  localparam int SW = DW + 4;

  logic [4:0][SW-1:0] wide;
  logic [SW-1:0]      sum2;
  logic [SW-1:0]      sum3;
  logic [SW-1:0]      sum4;
  logic [SW-1:0]      sum5;
  logic [DW-1:0]      next_data;
  logic               next_interp;
  vdg_taps_t          code;

  // zero-extend every tap so the weighted sums never wrap
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_wide
      assign wide[gi] = {{(SW-DW){1'b0}}, col_samples[gi]};
    end
  endgenerate

  // binomial sums, weights 1-1, 1-2-1, 1-3-3-1, 1-4-6-4-1
  assign code = vdg_taps_t'(tap_code);
  assign sum2 = wide[0] + wide[1];
  assign sum3 = wide[0] + (wide[1] << 1) + wide[2];
  assign sum4 = wide[0] + (wide[1] * SW'(3)) + (wide[2] * SW'(3)) + wide[3];
  assign sum5 = wide[0] + (wide[1] << 2) + (wide[2] * SW'(6)) + (wide[3] << 2) + wide[4];

  // tap selection and scaling by the weight total
  always_comb begin
    next_data   = col_samples[0];
    next_interp = 1'b0;
    unique case (code)
      VDG_TAP_INTERP: begin
        next_data   = col_samples[0];
        next_interp = 1'b1;
      end
      VDG_TAP_P2_INTERP: begin
        next_data   = sum2[DW:1];
        next_interp = 1'b1;
      end
      VDG_TAP_P3_INTERP: begin
        next_data   = sum3[DW+1:2];
        next_interp = 1'b1;
      end
      VDG_TAP_P4_INTERP: begin
        next_data   = sum4[DW+2:3];
        next_interp = 1'b1;
      end
      VDG_TAP_2: next_data = sum2[DW:1];
      VDG_TAP_3: next_data = sum3[DW+1:2];
      VDG_TAP_4: next_data = sum4[DW+2:3];
      VDG_TAP_5: next_data = sum5[DW+3:4];
    endcase
  end

  // result register, one cycle behind the column
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      filt_data        <= '0;
      filt_valid       <= 1'b0;
      filt_interpolate <= 1'b0;
    end else begin
      filt_valid <= col_valid;
      if (col_valid) begin
        filt_data        <= next_data;
        filt_interpolate <= next_interp;
      end
    end
  end

endmodule : vdg_vfilter

`default_nettype wire

// *** design/vdg_gate_ctrl.sv ***
// gate delay, converter interface and per-field timing control bank of the video front end
`timescale 1ns/10ps
`default_nettype none
`include "vdg_params.svh"

module vdg_gate_ctrl
  import vdg_pkg::*;
#(
  parameter int DW              = 8,
  parameter int RECOVERY_CYCLES = `VDG_RECOVERY_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               srst,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  output logic                    reg_rdata_valid,
  input  wire logic               line_start,
  input  wire logic               field_start,
  input  wire logic               field_odd,
  input  wire logic               luma_overflow,
  input  wire logic               chroma_overflow,
  input  wire logic [4:0][DW-1:0] col_samples,
  input  wire logic               col_valid,
  output logic                    gain_gate,
  output logic                    burst_gate,
  output logic      [7:0]         converter_reference_output,
  output logic                    converter_reference_output_en,
  output logic                    luma_sleep,
  output logic                    chroma_sleep,
  output logic                    decoder_clock_enable,
  output logic                    video_valid,
  output logic                    horizontal_reset_pulse,
  output logic                    horizontal_pulse_width_select,
  output logic      [2:0]         vertical_filter_taps,
  output logic      [DW-1:0]      filt_data,
  output logic                    filt_valid,
  output logic                    filt_interpolate
);

  localparam int RCW = $clog2(RECOVERY_CYCLES + 1);

  vdg_byte_t     gain_gate_delay;
  vdg_byte_t     burst_gate_delay_reg;
  vdg_byte_t     converter_interface;
  vdg_byte_t     even_field_timing_control;
  vdg_byte_t     odd_field_timing_control;
  vdg_byte_t     active_timing;
  logic [7:0]    line_count;
  logic          line_run;
  logic [6:0]    hr_count;
  vdg_hr_state_t hr_state;
  logic [RCW-1:0] recovery_count;

  // register decode
  logic      hit_gain;
  logic      hit_burst;
  logic      hit_cif;
  logic      hit_even;
  logic      hit_odd;
  vdg_byte_t next_rdata;

  assign hit_gain  = (reg_addr == `VDG_OFS_GAIN_GATE_DELAY);
  assign hit_burst = (reg_addr == `VDG_OFS_BURST_GATE_DELAY);
  assign hit_cif   = (reg_addr == `VDG_OFS_CONVERTER_IF);
  assign hit_even  = (reg_addr == `VDG_OFS_EVEN_TIMING);
  assign hit_odd   = (reg_addr == `VDG_OFS_ODD_TIMING);

  // read mux; reserved bits read zero, unmapped offsets read zero
  assign next_rdata =
      hit_gain  ? gain_gate_delay :
      hit_burst ? burst_gate_delay_reg :
      hit_cif   ? (converter_interface & `VDG_CIF_READ_MASK) :
      hit_even  ? (even_field_timing_control & `VDG_VTC_READ_MASK) :
      hit_odd   ? (odd_field_timing_control & `VDG_VTC_READ_MASK) :
      8'h00;

  // decoded control bits
  logic clock_sleep;
  logic gain_disable;
  logic adaptive_gain;
  logic decoder_run;
  logic any_overflow;

  assign clock_sleep   = converter_interface[`VDG_CIF_CLOCK_SLEEP];
  assign gain_disable  = converter_interface[`VDG_CIF_GAIN_DISABLE];
  assign adaptive_gain = converter_interface[`VDG_CIF_ADAPTIVE];
  // decoder logic halts but the register port does not
  assign decoder_run   = ~clock_sleep;
  assign any_overflow  = luma_overflow | chroma_overflow;

  // register port: reads answer one cycle later, never gated by sleep
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata       <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gain_gate_delay <= `VDG_RST_GAIN_GATE_DELAY;
    end else if (reg_wr && hit_gain) begin
      gain_gate_delay <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      burst_gate_delay_reg <= `VDG_RST_BURST_GATE_DELAY;
    end else if (reg_wr && hit_burst) begin
      burst_gate_delay_reg <= reg_wdata;
    end
  end

  // converter interface storage; reserved bit kept at zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      converter_interface <= `VDG_RST_CONVERTER_IF;
    end else if (reg_wr && hit_cif) begin
      // bit 5 dropped even if software writes it
      converter_interface <= reg_wdata & `VDG_CIF_READ_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      even_field_timing_control <= `VDG_RST_TIMING;
      odd_field_timing_control  <= `VDG_RST_TIMING;
    end else if (reg_wr) begin
      // bits 6 to 3 never stored
      if (hit_even) begin
        even_field_timing_control <= reg_wdata & `VDG_VTC_READ_MASK;
      end
      if (hit_odd) begin
        odd_field_timing_control <= reg_wdata & `VDG_VTC_READ_MASK;
      end
    end
  end

  // copy picked at field start so settings hold for the whole field
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_timing <= `VDG_RST_TIMING;
    end else if (field_start && decoder_run) begin
      active_timing <= field_odd ? odd_field_timing_control : even_field_timing_control;
    end
  end

  // control outputs taken from the active copy
  assign horizontal_pulse_width_select = active_timing[`VDG_VTC_PULSE_WIDTH];
  assign vertical_filter_taps          = active_timing[`VDG_VTC_TAPS_HI:`VDG_VTC_TAPS_LO];

  // luma sleep is the stored bit
  assign luma_sleep   = converter_interface[`VDG_CIF_LUMA_SLEEP];
  // chroma sleep is the stored bit, set at reset
  assign chroma_sleep = converter_interface[`VDG_CIF_CHROMA_SLEEP];

  // sample counter from line start; saturates so a late gate never wraps
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      line_count <= 8'h00;
      line_run   <= 1'b0;
    end else if (!decoder_run) begin
      line_run <= 1'b0;
    end else if (line_start) begin
      line_count <= 8'h00;
      line_run   <= 1'b1;
    end else if (line_run) begin
      if (line_count == 8'hFF) begin
        line_run <= 1'b0;
      end else begin
        line_count <= line_count + 8'h01;
      end
    end
  end

  // gate strobes, one cycle each
  logic next_gain_gate;
  logic next_burst_gate;

  assign next_gain_gate  = decoder_run && line_run && (line_count == gain_gate_delay);
  assign next_burst_gate = decoder_run && line_run && (line_count == burst_gate_delay_reg);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gain_gate  <= 1'b0;
      burst_gate <= 1'b0;
    end else begin
      gain_gate  <= next_gain_gate;
      burst_gate <= next_burst_gate;
    end
  end

  // horizontal reset pulse length
  logic [6:0] hr_width;
  // 64 cycles when bit 7 clear, 32 when set
  assign hr_width = horizontal_pulse_width_select ? 7'(`VDG_HORIZONTAL_RESET_PULSE_NARROW)
                                                  : 7'(`VDG_HORIZONTAL_RESET_PULSE_WIDE);

  // pulse sequencer; a new line start during a pulse restarts it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hr_state               <= VDG_HR_IDLE;
      hr_count               <= 7'h00;
      horizontal_reset_pulse <= 1'b0;
    end else if (!decoder_run) begin
      hr_state               <= VDG_HR_IDLE;
      horizontal_reset_pulse <= 1'b0;
    end else if (line_start) begin
      hr_state               <= VDG_HR_PULSE;
      hr_count               <= hr_width - 7'h01;
      horizontal_reset_pulse <= 1'b1;
    end else begin
      unique case (hr_state)
        VDG_HR_IDLE: begin
          horizontal_reset_pulse <= 1'b0;
        end
        VDG_HR_PULSE: begin
          if (hr_count == 7'h00) begin
            hr_state               <= VDG_HR_IDLE;
            horizontal_reset_pulse <= 1'b0;
          end else begin
            hr_count <= hr_count - 7'h01;
          end
        end
      endcase
    end
  end

  // adaptive gain steps the reference up on overflow, saturating
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      converter_reference_output <= `VDG_RST_REFERENCE;
    end else if (!adaptive_gain || gain_disable) begin
      converter_reference_output <= `VDG_RST_REFERENCE;
    end else if (decoder_run && any_overflow && converter_reference_output != 8'hFF) begin
      converter_reference_output <= converter_reference_output + 8'h01;
    end
  end

  // reference driven while the gain disable bit is clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      converter_reference_output_en <= 1'b0;
    end else begin
      converter_reference_output_en <= ~gain_disable;
    end
  end

  // clock enable follows the sleep bit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      decoder_clock_enable <= 1'b0;
    end else begin
      decoder_clock_enable <= ~clock_sleep;
    end
  end

  // recovery interval after waking before video is valid
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      recovery_count <= '0;
      video_valid    <= 1'b0;
    end else if (clock_sleep) begin
      recovery_count <= '0;
      video_valid    <= 1'b0;
    end else if (recovery_count == RCW'(RECOVERY_CYCLES - 1)) begin
      video_valid <= 1'b1;
    end else begin
      recovery_count <= recovery_count + RCW'(1);
    end
  end

  // vertical filter uses the active tap code
  vdg_vfilter #(
    .DW (DW)
  ) u_vfilter (
    .sys_clk          (sys_clk),
    .srst             (srst),
    .tap_code         (vertical_filter_taps),
    .col_samples      (col_samples),
    .col_valid        (col_valid),
    .filt_data        (filt_data),
    .filt_valid       (filt_valid),
    .filt_interpolate (filt_interpolate)
  );

endmodule : vdg_gate_ctrl

`default_nettype wire

// *** testbench/vdg_gate_ctrl_assertions.sv ***
// checker for the gate and filter control bank
`timescale 1ns/10ps
`default_nettype none
`include "vdg_params.svh"
module vdg_gate_ctrl_assertions
  import vdg_pkg::*;
#(
  parameter int RECOVERY_CYCLES = 20
) (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rdata_valid,
  input wire logic       line_start,
  input wire logic       field_start,
  input wire logic       field_odd,
  input wire logic       luma_overflow,
  input wire logic       chroma_overflow,
  input wire logic       gain_gate,
  input wire logic       burst_gate,
  input wire logic [7:0] converter_reference_output,
  input wire logic       converter_reference_output_en,
  input wire logic       luma_sleep,
  input wire logic       chroma_sleep,
  input wire logic       decoder_clock_enable,
  input wire logic       video_valid,
  input wire logic       horizontal_reset_pulse,
  input wire logic       horizontal_pulse_width_select,
  input wire logic [2:0] vertical_filter_taps
);
  logic [7:0] g_sh, b_sh, e_sh, o_sh, hc;
  logic [8:0] lc;
  wire        wr_cif = reg_wr && (reg_addr == `VDG_OFS_CONVERTER_IF);
  // shadows of delay and timing copies; line age saturates so stale lines never gate
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      {g_sh, b_sh} <= {`VDG_RST_GAIN_GATE_DELAY, `VDG_RST_BURST_GATE_DELAY};
      {e_sh, o_sh, hc, lc} <= {8'h00, 8'h00, 8'h00, 9'h1FF};
    end else begin
      if (reg_wr && reg_addr == `VDG_OFS_GAIN_GATE_DELAY) g_sh <= reg_wdata;
      if (reg_wr && reg_addr == `VDG_OFS_BURST_GATE_DELAY) b_sh <= reg_wdata;
      if (reg_wr && reg_addr == `VDG_OFS_EVEN_TIMING) e_sh <= reg_wdata;
      if (reg_wr && reg_addr == `VDG_OFS_ODD_TIMING) o_sh <= reg_wdata;
      hc <= horizontal_reset_pulse ? hc + 8'h01 : 8'h00;
      lc <= line_start ? 9'h001 : (lc == 9'h1FF ? lc : lc + 9'h001);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_rd_answer; reg_rd |=> reg_rdata_valid; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered next cycle");
  property p_sleep_bits;
    wr_cif |=> luma_sleep == $past(reg_wdata[2]) && chroma_sleep == $past(reg_wdata[1]);
  endproperty
  a_sleep_bits: assert property (p_sleep_bits)
    else $error("converter sleep outputs wrong after write");
  property p_ref_en;
    wr_cif |=> ##1 converter_reference_output_en == !$past(reg_wdata[4], 2);
  endproperty
  a_ref_en: assert property (p_ref_en)
    else $error("reference drive does not follow gain loop bit");
  property p_ref_step;
    converter_reference_output > $past(converter_reference_output)
      |-> $past(luma_overflow || chroma_overflow);
  endproperty
  a_ref_step: assert property (p_ref_step)
    else $error("reference rose without overflow");
  property p_video_off; !decoder_clock_enable |-> !video_valid; endproperty
  a_video_off: assert property (p_video_off)
    else $error("video valid while decoder clock stopped");
  property p_hr_width;
    // a pulse cut short by clock sleep is not a width error
    $fell(horizontal_reset_pulse) && decoder_clock_enable
      |-> hc == (horizontal_pulse_width_select ? 8'h20 : 8'h40);
  endproperty
  a_hr_width: assert property (p_hr_width)
    else $error("horizontal reset pulse width wrong");
  property p_gates;
    // delay compared as it stood when the count matched, a write may follow
    (gain_gate |-> lc == {1'b0, $past(g_sh)} + 9'h002)
      and (burst_gate |-> lc == {1'b0, $past(b_sh)} + 9'h002);
  endproperty
  a_gates: assert property (p_gates)
    else $error("gate pulse at wrong sample count");
  property p_field_apply;
    field_start |=> vertical_filter_taps == $past(field_odd ? o_sh[2:0] : e_sh[2:0])
      && horizontal_pulse_width_select == $past(field_odd ? o_sh[7] : e_sh[7]);
  endproperty
  a_field_apply: assert property (p_field_apply)
    else $error("field copy not applied");
  property p_field_hold;
    !$past(field_start) |-> $stable(vertical_filter_taps) && $stable(horizontal_pulse_width_select);
  endproperty
  a_field_hold: assert property (p_field_hold)
    else $error("timing outputs changed inside a field");
endmodule : vdg_gate_ctrl_assertions
bind vdg_gate_ctrl vdg_gate_ctrl_assertions #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) i_chk (
  .sys_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_valid, .line_start,
  .field_start, .field_odd, .luma_overflow, .chroma_overflow, .gain_gate, .burst_gate,
  .converter_reference_output, .converter_reference_output_en, .luma_sleep, .chroma_sleep,
  .decoder_clock_enable, .video_valid, .horizontal_reset_pulse,
  .horizontal_pulse_width_select, .vertical_filter_taps);
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench of the gate and filter control bank
`timescale 1ns/10ps
`default_nettype none
`include "vdg_params.svh"
module tb_top
  import vdg_pkg::*;
;
  localparam int RECOV = 20;
  localparam logic [7:0] adr_tab [6] = '{`VDG_OFS_GAIN_GATE_DELAY, `VDG_OFS_BURST_GATE_DELAY,
    `VDG_OFS_CONVERTER_IF, `VDG_OFS_EVEN_TIMING, `VDG_OFS_ODD_TIMING, 8'h70};
  localparam logic [7:0] rst_tab [6] = '{8'h68, 8'h5D, 8'h82, 8'h00, 8'h00, 8'h00};
  logic sys_clk, srst, reg_wr, reg_rd, line_start, field_start, field_odd, col_valid;
  logic luma_overflow, chroma_overflow, reg_rdata_valid, gain_gate, burst_gate, luma_sleep;
  logic chroma_sleep, decoder_clock_enable, video_valid, horizontal_reset_pulse, filt_valid;
  logic horizontal_pulse_width_select, filt_interpolate, converter_reference_output_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, converter_reference_output, filt_data;
  logic [2:0] vertical_filter_taps;
  logic [4:0][7:0] col_samples;
  int num_errors, check_count, seed;

  vdg_gate_ctrl #(.DW(8), .RECOVERY_CYCLES(RECOV)) i_vdg_gate_ctrl (
    .sys_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rdata_valid,
    .line_start, .field_start, .field_odd, .luma_overflow, .chroma_overflow, .col_samples,
    .col_valid, .gain_gate, .burst_gate, .converter_reference_output,
    .converter_reference_output_en, .luma_sleep, .chroma_sleep, .decoder_clock_enable,
    .video_valid, .horizontal_reset_pulse, .horizontal_pulse_width_select,
    .vertical_filter_taps, .filt_data, .filt_valid, .filt_interpolate);

  // free-running clock, 4 ns
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // strobes rise and fall on falling edges, so one idle cycle sits between transfers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk("rdata_valid", 16'h0001, {15'h0, reg_rdata_valid});
    chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
  endtask : rdchk

  task automatic strobe(input logic ln, input logic odd);
    @(negedge sys_clk);
    line_start = ln;
    field_start = !ln;
    field_odd = odd;
    @(negedge sys_clk);
    {line_start, field_start} = 2'b00;
  endtask : strobe

  // readable bits of each place; unmapped reads zero
  function automatic logic [7:0] rmask(input logic [7:0] a);
    case (a)
      `VDG_OFS_CONVERTER_IF: rmask = `VDG_CIF_READ_MASK;
      `VDG_OFS_EVEN_TIMING, `VDG_OFS_ODD_TIMING: rmask = `VDG_VTC_READ_MASK;
      `VDG_OFS_GAIN_GATE_DELAY, `VDG_OFS_BURST_GATE_DELAY: rmask = 8'hFF;
      default: rmask = 8'h00;
    endcase
  endfunction : rmask

  // binomial taps, truncating; codes 4 to 6 drop interpolation only, code 7 is the five-tap sum
  function automatic logic [7:0] fmodel(input logic [2:0] c, input logic [4:0][7:0] s);
    logic [11:0] t0, t1, t2, t3, t4;
    {t0, t1, t2, t3, t4} = {4'h0, s[0], 4'h0, s[1], 4'h0, s[2], 4'h0, s[3], 4'h0, s[4]};
    case (c)
      3'h0: fmodel = s[0];
      3'h1, 3'h4: fmodel = 8'((t0 + t1) >> 1);
      3'h2, 3'h5: fmodel = 8'((t0 + 12'h2 * t1 + t2) >> 2);
      3'h3, 3'h6: fmodel = 8'((t0 + 12'h3 * t1 + 12'h3 * t2 + t3) >> 3);
      default: fmodel = 8'((t0 + 12'h4 * t1 + 12'h6 * t2 + 12'h4 * t3 + t4) >> 4);
    endcase
  endfunction : fmodel

  // watchdog well past the expected run
  initial begin
    #(40000 * 4);
    num_errors++;
    finish_test();
  end

  initial begin
    logic [7:0] a, d, gd, bd, tc;
    logic [15:0] gk, bk, hc;
    int n;
    seed = 32'h3054ADB5;
    {reg_wr, reg_rd, line_start, field_start, field_odd, col_valid} = 6'h00;
    {luma_overflow, chroma_overflow, reg_addr, reg_wdata, col_samples} = '0;
    srst = 1'b1;
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    strobe(1'b1, 1'b0);
    chk("chroma_sleep", 16'h0001, {15'h0, chroma_sleep});
    chk("luma_sleep", 16'h0000, {15'h0, luma_sleep});
    for (int i = 0; i < 6; i++) begin
      rdchk(adr_tab[i], rst_tab[i]);
    end
    $display("reset values done");
    for (int i = 0; i < 24; i++) begin
      a = adr_tab[$unsigned($random(seed)) % 6];
      d = 8'($random(seed));
      wr(a, d);
      rdchk(a, d & rmask(a));
    end
    wr(`VDG_OFS_CONVERTER_IF, 8'h00);
    $display("register access done");
    for (int i = 0; i < 4; i++) begin
      gd = (i == 0) ? 8'h00 : ((i == 1) ? 8'hF0 : 8'($unsigned($random(seed)) % 241));
      bd = 8'($unsigned($random(seed)) % 241);
      tc = 8'($random(seed)) & 8'h87;
      wr(`VDG_OFS_GAIN_GATE_DELAY, gd);
      wr(`VDG_OFS_BURST_GATE_DELAY, bd);
      // odd and even fields alternate so both copies get applied
      wr(i[0] ? `VDG_OFS_ODD_TIMING : `VDG_OFS_EVEN_TIMING, tc);
      wr(i[0] ? `VDG_OFS_EVEN_TIMING : `VDG_OFS_ODD_TIMING, ~tc & 8'h87);
      strobe(1'b0, i[0]);
      chk("taps", {13'h0, tc[2:0]}, {13'h0, vertical_filter_taps});
      chk("width_select", {15'h0, tc[7]}, {15'h0, horizontal_pulse_width_select});
      wr(i[0] ? `VDG_OFS_ODD_TIMING : `VDG_OFS_EVEN_TIMING, ~tc & 8'h87);
      strobe(1'b1, 1'b0);
      {gk, bk, hc} = '0;
      for (int k = 1; k <= 300; k++) begin
        gk = (gain_gate === 1'b1) ? 16'(k) : gk;
        bk = (burst_gate === 1'b1) ? 16'(k) : bk;
        hc = hc + {15'h0, horizontal_reset_pulse === 1'b1};
        @(negedge sys_clk);
      end
      chk("gain_gate_at", {8'h00, gd} + 16'h0002, gk);
      chk("burst_gate_at", {8'h00, bd} + 16'h0002, bk);
      chk("horizontal_reset_pulse_width", tc[7] ? 16'h0020 : 16'h0040, hc);
      chk("taps_held", {13'h0, tc[2:0]}, {13'h0, vertical_filter_taps});
    end
    $display("line timing done");
    // columns stand for a picture under 193 pixels, so all codes are legal
    for (int c = 0; c < 8; c++) begin
      wr(`VDG_OFS_EVEN_TIMING, 8'(c));
      strobe(1'b0, 1'b0);
      col_samples = 40'({$random(seed), $random(seed)});
      col_valid = 1'b1;
      @(negedge sys_clk);
      col_valid = 1'b0;
      chk("filt_valid", 16'h0001, {15'h0, filt_valid});
      chk("filt_data", {8'h00, fmodel(3'(c), col_samples)}, {8'h00, filt_data});
      chk("filt_interp", {15'h0, c < 4}, {15'h0, filt_interpolate});
    end
    $display("vertical filter done");
    wr(`VDG_OFS_CONVERTER_IF, 8'h01);
    n = 1 + $unsigned($random(seed)) % 9;
    luma_overflow = 1'b1;
    repeat (n) @(negedge sys_clk);
    {luma_overflow, chroma_overflow} = 2'b01;
    repeat (2) @(negedge sys_clk);
    chroma_overflow = 1'b0;
    chk("reference", 16'h0082 + 16'(n), {8'h00, converter_reference_output});
    chk("reference_en", 16'h0001, {15'h0, converter_reference_output_en});
    wr(`VDG_OFS_CONVERTER_IF, 8'h11);
    luma_overflow = 1'b1;
    repeat (3) @(negedge sys_clk);
    luma_overflow = 1'b0;
    chk("reference_off", 16'h0080, {8'h00, converter_reference_output});
    chk("reference_en_off", 16'h0000, {15'h0, converter_reference_output_en});
    $display("reference control done");
    wr(`VDG_OFS_CONVERTER_IF, 8'h08);
    @(negedge sys_clk);
    chk("clock_enable", 16'h0000, {15'h0, decoder_clock_enable});
    chk("video_valid", 16'h0000, {15'h0, video_valid});
    d = 8'($random(seed));
    wr(`VDG_OFS_GAIN_GATE_DELAY, d);
    rdchk(`VDG_OFS_GAIN_GATE_DELAY, d);
    wr(`VDG_OFS_CONVERTER_IF, 8'h00);
    n = 0;
    while (video_valid !== 1'b1 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("recovery", 16'h0001, {15'h0, n >= RECOV - 1 && n <= RECOV + 2});
    $display("clock sleep done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
